// ---- shared/tmr_defs.svh ----
// Constants for the two-wire memory read path
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Memory geometry
`define TMR_ADDR_W 13
`define TMR_DATA_W 8
`define TMR_ADDR_RESET 13'h0000

// Slave address byte layout
`define TMR_TYPE_MSB 7
`define TMR_TYPE_LSB 4
`define TMR_SEL_MSB 3
`define TMR_SEL_LSB 1
`define TMR_RW_BIT 0
// Device type code; the value is arbitrary
`define TMR_DEV_TYPE 4'h5

// Bit counter value of the eighth bit of a byte
`define TMR_LAST_BIT 3'h7

`endif

// ---- shared/tmr_pkg.sv ----
// Types shared by the two-wire memory read path
package tmr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_DEVACK,
    ST_ADDRHI,
    ST_HIACK,
    ST_ADDRLO,
    ST_LOACK,
    ST_WDATA,
    ST_RDBYTE,
    ST_RDACK
  } tmr_state_t;

endpackage

// ---- hdl/tmr_fetch_mem.sv ----
// Memory array and system-side responder of the byte fetch handshake
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_fetch_mem
  import tmr_pkg::*;
#(
  parameter int ADDR_W = `TMR_ADDR_W,
  parameter int DATA_W = `TMR_DATA_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fill_en,
  input wire logic [ADDR_W-1:0] fill_addr,
  input wire logic [DATA_W-1:0] fill_data,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_ack,
  output logic [DATA_W-1:0] fetch_data
);

  if (ADDR_W < 1 || ADDR_W > 20 || DATA_W < 1) begin : g_bad_geometry
    $error("tmr_fetch_mem: unsupported geometry");
  end

  logic [DATA_W-1:0] mem_r [0:(1 << ADDR_W)-1];
  logic [1:0] req_sync_r;
  logic ack_r;
  logic [DATA_W-1:0] data_r;

  // Array contents are not reset; the write side fills them
  always_ff @(posedge clk) begin
    if (fill_en) begin
      mem_r[fill_addr] <= fill_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_sync_r <= 2'h0;
    end else begin
      req_sync_r <= {req_sync_r[0], fetch_req};
    end
  end

  // Address is held stable by the requester from request until acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      data_r <= '0;
    end else if (req_sync_r[1] && !ack_r) begin
      data_r <= mem_r[fetch_addr];
      ack_r <= 1'b1;
    end else if (!req_sync_r[1]) begin
      ack_r <= 1'b0;
    end
  end

  assign fetch_ack = ack_r;
  assign fetch_data = data_r;

endmodule

// ---- hdl/tmr_read_path.sv ----
// Two-wire memory read path: link-side protocol engine and fetch crossing
//
// Functional notes
// - Address byte with read bit starts read
// - Current read starts at latched address
// - Unlimited bytes, address increments per byte
// - Master acknowledge sends next sequential byte, fetched at the eighth bit
// - Unterminated read keeps driving further bytes
// - Address 1FFF wraps to 0000
// - Write header loads the address latch
// - Repeated start aborts write, begins read
// - Type, select pins and read/write decoded
// - No-ack ends read and releases line
// - Bytes shift most significant bit first
// - Thirteen-bit address, upper three bits ignored
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_read_path
  import tmr_pkg::*;
#(
  parameter int ADDR_W = `TMR_ADDR_W,
  parameter logic [3:0] DEV_TYPE = `TMR_DEV_TYPE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] device_select_pins,
  input wire logic fill_en,
  input wire logic [ADDR_W-1:0] fill_addr,
  input wire logic [7:0] fill_data,
  output logic read_active
);

  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
    $error("tmr_read_path: ADDR_W must lie in 9..16");
  end

  localparam int HI_W = ADDR_W - 8;

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = (a == {ADDR_W{1'b1}}) ? '0 : a + 1'b1;
  endfunction

  // Link-domain reset, taken over from the system reset
  logic [1:0] lrst_sync_r;
  logic link_rst_n;

  always_ff @(posedge link_clk) begin
    lrst_sync_r <= {lrst_sync_r[0], rst_n};
  end

  assign link_rst_n = lrst_sync_r[1];

  // Pin synchronisers and edge history
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [2:0] sel_sync_r [0:1];
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      sel_sync_r[0] <= 3'h0;
      sel_sync_r[1] <= 3'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      sel_sync_r[0] <= device_select_pins;
      sel_sync_r[1] <= sel_sync_r[0];
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  // Data may only move while the clock is low; a move while high is a condition
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Protocol state
  tmr_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic [7:0] rx_byte;
  logic rw_r;
  logic ack_phase_r;
  logic load_r;
  logic [HI_W-1:0] hi_r;
  logic byte_done;
  logic dev_hit;

  assign rx_byte = {rx_r[6:0], sda_s};
  assign byte_done = scl_rise && (bit_cnt_r == `TMR_LAST_BIT);
  assign dev_hit = (rx_byte[`TMR_TYPE_MSB:`TMR_TYPE_LSB] == DEV_TYPE) &&
                   (rx_byte[`TMR_SEL_MSB:`TMR_SEL_LSB] == sel_sync_r[1]);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      rx_r <= 8'h00;
      rw_r <= 1'b0;
      ack_phase_r <= 1'b0;
      load_r <= 1'b0;
      hi_r <= '0;
    end else if (bus_start) begin
      state_r <= ST_DEVADDR;
      bit_cnt_r <= 3'h0;
      ack_phase_r <= 1'b0;
      load_r <= 1'b0;
    end else if (bus_stop) begin
      state_r <= ST_IDLE;
      ack_phase_r <= 1'b0;
      load_r <= 1'b0;
    end else if (scl_rise) begin
      rx_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      case (state_r)
        ST_DEVADDR: begin
          if (byte_done) begin
            // read bit picked up with the address
            if (dev_hit) begin
              state_r <= ST_DEVACK;
              rw_r <= rx_byte[`TMR_RW_BIT];
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDRHI: begin
          if (byte_done) begin
            // upper bits of the high byte dropped
            hi_r <= rx_byte[HI_W-1:0];
            state_r <= ST_HIACK;
          end
        end
        ST_ADDRLO: begin
          if (byte_done) begin
            state_r <= ST_LOACK;
          end
        end
        ST_RDBYTE: begin
          if (byte_done) begin
            state_r <= ST_RDACK;
          end
        end
        ST_RDACK: begin
          bit_cnt_r <= 3'h0;
          if (sda_s) begin
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_RDBYTE;
            load_r <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_r)
        ST_DEVACK, ST_HIACK, ST_LOACK: begin
          if (!ack_phase_r) begin
            ack_phase_r <= 1'b1;
          end else begin
            ack_phase_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            if (state_r == ST_DEVACK) begin
              state_r <= rw_r ? ST_RDBYTE : ST_ADDRHI;
            end else if (state_r == ST_HIACK) begin
              state_r <= ST_ADDRLO;
            end else begin
              state_r <= ST_WDATA;
            end
          end
        end
        ST_RDBYTE: begin
          load_r <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Fetch crossing state
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] want_addr_r;
  logic [ADDR_W-1:0] fetch_addr_r;
  logic fetch_pend_r;
  logic fetch_req_r;
  logic [1:0] ack_sync_r;
  logic [7:0] fetch_data_r;
  logic mem_ack;
  logic [7:0] mem_data;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      addr_r <= `TMR_ADDR_RESET;
    end else if (byte_done && state_r == ST_ADDRLO) begin
      addr_r <= {hi_r, rx_byte};
    end else if (byte_done && state_r == ST_RDBYTE) begin
      addr_r <= addr_inc(addr_r);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ack_sync_r <= 2'h0;
    end else begin
      ack_sync_r <= {ack_sync_r[0], mem_ack};
    end
  end

  // Four-phase handshake; a new fetch waits until the previous one has closed
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      want_addr_r <= '0;
      fetch_addr_r <= '0;
      fetch_pend_r <= 1'b0;
      fetch_req_r <= 1'b0;
      fetch_data_r <= 8'h00;
    end else begin
      if (!fetch_req_r && !ack_sync_r[1] && fetch_pend_r) begin
        fetch_req_r <= 1'b1;
        fetch_addr_r <= want_addr_r;
        fetch_pend_r <= 1'b0;
      end else if (fetch_req_r && ack_sync_r[1]) begin
        fetch_req_r <= 1'b0;
        fetch_data_r <= mem_data;
      end
      if (byte_done && state_r == ST_DEVADDR && dev_hit && rx_byte[`TMR_RW_BIT]) begin
        // first byte comes from the latch as it stands
        want_addr_r <= addr_r;
        fetch_pend_r <= 1'b1;
      end else if (byte_done && state_r == ST_RDBYTE) begin
        // prefetch so the byte is ready by the next fall
        want_addr_r <= addr_inc(addr_r);
        fetch_pend_r <= 1'b1;
      end
    end
  end

  // Data line drive, changed on falling clock edges and released at start, stop or reset
  logic oe_r;
  logic [7:0] tx_r;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n || bus_start || bus_stop) begin
      oe_r <= 1'b0;
      if (!link_rst_n) begin
        tx_r <= 8'h00;
      end
    end else if (scl_fall) begin
      case (state_r)
        ST_DEVACK: begin
          if (!ack_phase_r) begin
            oe_r <= 1'b1;
          end else if (rw_r) begin
            // first data bit on the clock after the address acknowledge
            oe_r <= ~fetch_data_r[7];
            tx_r <= {fetch_data_r[6:0], 1'b0};
          end else begin
            oe_r <= 1'b0;
          end
        end
        ST_HIACK, ST_LOACK: begin
          oe_r <= ~ack_phase_r;
        end
        ST_RDBYTE: begin
          if (load_r) begin
            oe_r <= ~fetch_data_r[7];
            tx_r <= {fetch_data_r[6:0], 1'b0};
          end else begin
            oe_r <= ~tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
        default: begin
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  logic read_active_r;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      read_active_r <= 1'b0;
    end else begin
      read_active_r <= (state_r == ST_RDBYTE) || (state_r == ST_RDACK);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign read_active = read_active_r;

  tmr_fetch_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(8)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .fill_en(fill_en),
    .fill_addr(fill_addr),
    .fill_data(fill_data),
    .fetch_req(fetch_req_r),
    .fetch_addr(fetch_addr_r),
    .fetch_ack(mem_ack),
    .fetch_data(mem_data)
  );

endmodule

// ---- testbench/tmr_read_path_properties.sv ----
// Port assertions for the two-wire memory read path
`timescale 1ns/1ps
module tmr_read_path_properties #(
  parameter int ADDR_W = 13,
  parameter logic [3:0] DEV_TYPE = 4'h5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [2:0] device_select_pins,
  input wire logic fill_en,
  input wire logic [ADDR_W-1:0] fill_addr,
  input wire logic [7:0] fill_data,
  input wire logic read_active
);
  logic scl_q, sda_q, first_r;
  logic [3:0] bit_r;
  logic [7:0] dev_r;
  wire rise = scl && !scl_q;
  wire ninth = rise && bit_r == 4'h8;
  wire start_ev = scl && scl_q && sda_q && !sda_in;
  wire stop_ev = scl && scl_q && !sda_q && sda_in;
  wire hit = dev_r[7:4] == DEV_TYPE && dev_r[3:1] == device_select_pins;
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge link_clk) begin
    scl_q <= scl;
    sda_q <= sda_in;
  end
  // Bit position in the byte; a start realigns it
  always_ff @(posedge link_clk) begin
    if (!rst_n || start_ev) begin
      bit_r <= 4'h0;
      first_r <= 1'b1;
    end else if (rise) begin
      bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      first_r <= first_r && bit_r != 4'h8;
    end
  end
  // Slave address byte as seen on the wire
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      dev_r <= 8'h00;
    end else if (rise && first_r && bit_r != 4'h8) begin
      dev_r <= {dev_r[6:0], sda_in};
    end
  end
  a_drive_low: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_raise_low_clk: assert property ($rose(sda_oe) |-> !scl)
    else $error("drive began with scl high");
  a_addr_ack: assert property (ninth && first_r |-> sda_oe == hit)
    else $error("address ack wrong");
  a_ack_free: assert property (ninth && !first_r && dev_r[0] && hit |-> !sda_oe)
    else $error("line held in ack clock");
  a_start_end: assert property (start_ev |-> ##[1:8] !read_active)
    else $error("start did not end read");
  a_stop_end: assert property (stop_ev |-> ##[1:8] !read_active)
    else $error("stop did not end read");
  a_read_begin: assert property ($rose(read_active) |-> dev_r[0] && hit && !scl)
    else $error("read began without read address");
  a_end_release: assert property ($fell(read_active) |-> !sda_oe)
    else $error("line held after read end");
  c_read: cover property ($rose(read_active));
  c_start_in_read: cover property (start_ev && read_active);
  c_held_stop: cover property (ninth && !first_r && !sda_in && read_active);
endmodule

// ---- testbench/tmr_master_model.sv ----
// Two-wire bus master model: clocks the link, senses the wired data line
`timescale 1ns/1ps
module tmr_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Low phase of 240 ns, data moved halfway, then the clock rises
  task automatic lo(input logic b);
    scl = 1'b0;
    w(15);
    sda_low = b;
    w(15);
    scl = 1'b1;
  endtask
  // Data edge with the clock high: a fall is a start, a rise a stop
  task automatic cond(input logic b);
    w(30);
    sda_low = b;
    w(30);
  endtask
  task automatic start();
    lo(1'b0);
    cond(1'b1);
    scl = 1'b0;
  endtask
  task automatic stop();
    lo(1'b1);
    cond(1'b0);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      lo(!b[i]);
      w(30);
    end
    lo(1'b0);
    w(15);
    ack = !sda;
    w(15);
  endtask
  task automatic rbyte(input int nb, input logic ack, output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < nb; i++) begin
      lo(1'b0);
      w(15);
      d = {d[6:0], sda};
      w(15);
    end
    lo(ack);
    w(30);
  endtask
endmodule

// ---- testbench/test_tmr_read_path.sv ----
// Self-checking bench for the two-wire memory read path
`timescale 1ns/1ps
module test_tmr_read_path;
  localparam logic [3:0] DEV = 4'h5;
  localparam logic [2:0] SEL = 3'h5;
  typedef struct {bit sel; logic [7:0] hi; logic [7:0] lo; int n; int mode; logic [12:0] a;} tmr_row_t;
  tmr_row_t rows[4];
  logic clk, link_clk, rst_n, scl, sda, sda_low, sda_out, sda_oe, fill_en, read_active, ack;
  logic [12:0] fill_addr, e;
  logic [7:0] fill_data, d;
  int error_cnt = 0;
  int n_checks = 0;
  assign sda = !(sda_low || sda_oe);
  tmr_read_path #(.ADDR_W(13), .DEV_TYPE(DEV)) i_tmr_read_path (.clk(clk), .rst_n(rst_n),
    .link_clk(link_clk), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .device_select_pins(SEL), .fill_en(fill_en), .fill_addr(fill_addr),
    .fill_data(fill_data), .read_active(read_active));
  tmr_master_model i_tmr_master_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h5};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic addr(input logic rw);
    i_tmr_master_model.start();
    i_tmr_master_model.wbyte({DEV, SEL, rw}, ack);
    chk1(ack, 1'b1);
  endtask
  task automatic sel_addr(input logic [7:0] hi, input logic [7:0] lo);
    addr(1'b0);
    i_tmr_master_model.wbyte(hi, ack);
    chk1(ack, 1'b1);
    i_tmr_master_model.wbyte(lo, ack);
    chk1(ack, 1'b1);
  endtask
  // Hang guard, about three times the expected run
  initial begin
    #400_000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    fill_en = 1'b0;
    fill_addr = 13'h0000;
    fill_data = 8'h00;
    rows[0] = '{1'b1, 8'hE1, 8'h23, 3, 0, 13'h0123};
    rows[1] = '{1'b0, 8'h00, 8'h00, 1, 1, 13'h0126};
    rows[2] = '{1'b1, 8'hFF, 8'hFE, 4, 2, 13'h1FFE};
    rows[3] = '{1'b0, 8'h00, 8'h00, 2, 3, 13'h0002};
    // Held past both synchronisers, longer than three cycles
    repeat (12) @(negedge clk);
    chk1(sda_oe, 1'b0);
    chk1(read_active, 1'b0);
    rst_n = 1'b1;
    fill_en = 1'b1;
    for (int i = 0; i < 48; i++) begin
      fill_addr = 13'((i / 16) * 'h0120 + (i / 32) * 'h1DB8 + i % 16);
      fill_data = pat(fill_addr);
      @(negedge clk);
    end
    fill_en = 1'b0;
    repeat (30) @(negedge clk);
    foreach (rows[r]) begin
      if (rows[r].sel) sel_addr(rows[r].hi, rows[r].lo);
      addr(1'b1);
      e = rows[r].a;
      for (int k = 0; k < rows[r].n; k++) begin
        i_tmr_master_model.rbyte(8, k < rows[r].n - 1 || rows[r].mode == 2, d);
        chk8(d, pat(e));
        e = e + 13'h0001;
      end
      case (rows[r].mode)
        0: i_tmr_master_model.stop();
        1: begin
          i_tmr_master_model.start();
          i_tmr_master_model.stop();
        end
        2: i_tmr_master_model.cond(1'b0);
        3: begin
          i_tmr_master_model.cond(1'b1);
          i_tmr_master_model.stop();
        end
      endcase
      chk1(read_active, 1'b0);
    end
    // Acked byte then a stop attempt: the next byte's zero top bit blocks it
    sel_addr(8'h00, 8'h02);
    addr(1'b1);
    i_tmr_master_model.rbyte(8, 1'b1, d);
    chk8(d, pat(13'h0002));
    i_tmr_master_model.stop();
    chk1(read_active, 1'b1);
    chk1(sda, 1'b0);
    i_tmr_master_model.rbyte(7, 1'b0, d);
    chk8({1'b0, d[6:0]}, pat(13'h0003));
    i_tmr_master_model.stop();
    for (int j = 0; j < 2; j++) begin
      i_tmr_master_model.start();
      i_tmr_master_model.wbyte(j == 0 ? {DEV, ~SEL, 1'b1} : {~DEV, SEL, 1'b1}, ack);
      chk1(ack, 1'b0);
      i_tmr_master_model.stop();
      chk1(read_active, 1'b0);
    end
    tally_and_finish();
  end
endmodule
bind tmr_read_path tmr_read_path_properties #(.ADDR_W(ADDR_W), .DEV_TYPE(DEV_TYPE))
  i_tmr_read_path_properties (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
  .fill_en(fill_en), .fill_addr(fill_addr), .fill_data(fill_data), .read_active(read_active));
